/* File: common/hmp_pkg.sv */
/*
  Constants, field positions and reset values for the host mailbox port.
  Assumes that both the host port and the local port are synchronous to the
  system clock, and that each port strobe lasts one enabled clock cycle.
*/
package hmp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Host port offsets
  localparam logic       HOST_OFS_CMD_STAT = 1'h0;
  localparam logic       HOST_OFS_DATA     = 1'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Local port offsets
  localparam logic [1:0] LOC_OFS_CMD_STAT  = 2'h0;
  localparam logic [1:0] LOC_OFS_DATA      = 2'h1;
  localparam logic [1:0] LOC_OFS_FLAGS_CTL = 2'h2;
  localparam logic [1:0] LOC_OFS_VECTOR    = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // host_status_out fields
  localparam int unsigned STAT_IN_EMPTY    = 7;
  localparam int unsigned STAT_OUT_PENDING = 6;
  localparam int unsigned STAT_SW_HI       = 5;
  localparam int unsigned STAT_SW_LO       = 2;
  localparam int unsigned STAT_CMD_EMPTY   = 1;
  localparam int unsigned STAT_RESET_N     = 0;

  ////////////////////////////////////////////////////////////////////////////
  // handshake_flags fields
  localparam int unsigned FLG_OUT_SLOT_EMPTY    = 7;
  localparam int unsigned FLG_IN_AVAIL          = 6;
  localparam int unsigned FLG_HOST_INT_PEND     = 3;
  localparam int unsigned FLG_STATUS_SLOT_EMPTY = 1;
  localparam int unsigned FLG_CMD_AVAIL         = 0;
  localparam logic [7:0]  FLG_ONES_MASK         = 8'h34;

  ////////////////////////////////////////////////////////////////////////////
  // Local control fields
  localparam int unsigned CTL_HOST_IE = 0;
  localparam int unsigned CTL_LOC_IE  = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and fixed values
  localparam logic [3:0] RST_STAT_SW      = 4'h0;
  localparam logic       RST_CMD_EMPTY    = 1'h1;
  localparam logic       RST_STATUS_EMPTY = 1'h1;
  localparam logic       RST_CLEAR        = 1'h0;
  localparam logic [7:0] RST_BYTE         = 8'h00;
  localparam logic [7:0] LOC_INT_VECTOR   = 8'hfc;
  localparam logic [7:0] UNUSED_READ      = 8'h00;

endpackage : hmp_pkg

/* File: verilog/hmp_mailbox.sv */
/*
  Host mailbox port: byte mailbox between a bus host doing port I/O and the
  board's local processor, with handshake flags, software status bits, a
  local interrupt on host accesses and a vectored host interrupt.
  Assumes host and local strobes are synchronous single-cycle pulses on
  sys_clk_i, qualified by clk_en_i, and that at most one strobe per port is
  active in a cycle.
  The reserved software-reset command series is not decoded here: every
  reset of this block comes from rst_n_i.
*/
`timescale 1ns/1ps

// Operation
// [R1] Host-written command byte held for local reads; not cleared by reset.
// [R2] Host avoids the reserved six-byte software reset command series.
// [R3] Host command write clears status command-empty bit.
// [R4] Command-empty changes by local status write bit 1; reset sets it.
// [R5] Status bit 7 cleared by host data write, set by local read.
// [R6] Status bit 6 set by local data write, cleared by host read.
// [R7] Status bits 5..2 hold local-written software status; reset clears.
// [R8] Status bit 0 shows internal reset line; local writes ignored.
// [R9] With local enable, host accesses raise a local interrupt.
// [R10] Host-to-local data byte unreset; overwrites and re-reads allowed.
// [R11] Local-to-host data byte unreset; overwrites and re-reads allowed.
// [R12] Flags bit 7 cleared by local data write, set by host read.
// [R13] Flags bit 6 set by host data write, cleared by local read.
// [R14] Flags bit 3 shows host interrupt pending until host acknowledge.
// [R15] Flags bit 1 set by host status read, cleared by local write.
// [R16] Local vector write requests a host interrupt when host enable set.
// [R17] Host writes data only after status bit 7 shows slot empty.
// [R18] Flags bits 5, 4, 2 read one; all flags read-only.
// [R19] Flags bit 0 set by command write, cleared by setting command-empty.
// [R20] Local enable is control bit 2; acknowledge supplies vector fc.
// [R21] Host acknowledge returns vector, releases request; reset withdraws it.
// [R22] Vector writes ignored while host enable clear; vector unreset.
module hmp_mailbox (
  // Clock, reset, enable
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       clk_en_i,
  // Host port
  input  wire logic       host_addr_i,
  input  wire logic       host_wr_i,
  input  wire logic       host_rd_i,
  input  wire logic [7:0] host_wdata_i,
  output logic      [7:0] host_rdata_o,
  // Host interrupt
  output logic            host_int_n_o,
  input  wire logic       host_inta_i,
  output logic      [7:0] host_vec_o,
  // Local port
  input  wire logic [1:0] loc_addr_i,
  input  wire logic       loc_wr_i,
  input  wire logic       loc_rd_i,
  input  wire logic [7:0] loc_wdata_i,
  output logic      [7:0] loc_rdata_o,
  // Local interrupt
  output logic            loc_int_o,
  input  wire logic       loc_inta_i,
  output logic      [7:0] loc_vec_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State types

  // Control state, cleared or set by board reset
  typedef struct packed {
    logic [3:0] stat_sw;
    logic       cmd_empty;
    logic       cmd_avail;
    logic       in_full;
    logic       out_pending;
    logic       status_empty;
    logic       host_ie;
    logic       loc_ie;
    logic       host_int_pend;
    logic       loc_int_pend;
    logic [7:0] host_rdata;
    logic [7:0] loc_rdata;
    logic [7:0] host_vec;
    logic [7:0] loc_vec;
  } hmp_ctl_t;

  // Mailbox bytes keep their contents across reset, so they live apart
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] in_data;
    logic [7:0] out_data;
    logic [7:0] vector;
  } hmp_data_t;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] rst_sync_q;
  logic       rst_int_n;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end

  assign rst_int_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Access decode

  hmp_ctl_t  ctl_q;
  hmp_ctl_t  ctl_d;
  hmp_data_t dat_q;
  hmp_data_t dat_d;

  logic host_cmd_wr;
  logic host_data_wr;
  logic host_stat_rd;
  logic host_data_rd;
  logic loc_stat_wr;
  logic loc_data_wr;
  logic loc_ctl_wr;
  logic loc_vec_wr;
  logic loc_data_rd;
  logic loc_rd_any;
  logic host_access;
  logic host_ack;
  logic loc_ack;

  // Frozen strobes keep a stalled clock enable from counting an access twice
  function automatic logic hit(input logic stb, input logic en);
    hit = stb & en;
  endfunction : hit

  // Strobe decode for one host offset
  function automatic logic host_sel(
    input logic stb,
    input logic en,
    input logic addr,
    input logic ofs
  );
    host_sel = hit(stb, en) & (addr == ofs);
  endfunction : host_sel

  // Strobe decode for one local offset
  function automatic logic loc_sel(
    input logic       stb,
    input logic       en,
    input logic [1:0] addr,
    input logic [1:0] ofs
  );
    loc_sel = hit(stb, en) & (addr == ofs);
  endfunction : loc_sel

  assign host_cmd_wr  = host_sel(host_wr_i, clk_en_i, host_addr_i, hmp_pkg::HOST_OFS_CMD_STAT);
  assign host_data_wr = host_sel(host_wr_i, clk_en_i, host_addr_i, hmp_pkg::HOST_OFS_DATA);
  assign host_stat_rd = host_sel(host_rd_i, clk_en_i, host_addr_i, hmp_pkg::HOST_OFS_CMD_STAT);
  assign host_data_rd = host_sel(host_rd_i, clk_en_i, host_addr_i, hmp_pkg::HOST_OFS_DATA);
  assign loc_stat_wr  = loc_sel(loc_wr_i, clk_en_i, loc_addr_i, hmp_pkg::LOC_OFS_CMD_STAT);
  assign loc_data_wr  = loc_sel(loc_wr_i, clk_en_i, loc_addr_i, hmp_pkg::LOC_OFS_DATA);
  assign loc_ctl_wr   = loc_sel(loc_wr_i, clk_en_i, loc_addr_i, hmp_pkg::LOC_OFS_FLAGS_CTL);
  assign loc_vec_wr   = loc_sel(loc_wr_i, clk_en_i, loc_addr_i, hmp_pkg::LOC_OFS_VECTOR);
  assign loc_data_rd  = loc_sel(loc_rd_i, clk_en_i, loc_addr_i, hmp_pkg::LOC_OFS_DATA);
  assign loc_rd_any   = hit(loc_rd_i, clk_en_i);
  assign host_ack     = hit(host_inta_i, clk_en_i);
  assign loc_ack      = hit(loc_inta_i, clk_en_i);

  assign host_access = host_cmd_wr | host_data_wr | host_stat_rd | host_data_rd; // R9

  ////////////////////////////////////////////////////////////////////////////
  // Read views

  logic [7:0] status_view;
  logic [7:0] flags_view;

  // Read data shares the control reset, so a host read while reset is held
  // returns 00, which shows the reset line low in bit 0
  always_comb begin
    status_view                                        = 8'h00;
    status_view[hmp_pkg::STAT_IN_EMPTY]                = ~ctl_q.in_full;      // R5
    status_view[hmp_pkg::STAT_OUT_PENDING]             = ctl_q.out_pending;   // R6
    status_view[hmp_pkg::STAT_SW_HI:hmp_pkg::STAT_SW_LO] = ctl_q.stat_sw;     // R7
    status_view[hmp_pkg::STAT_CMD_EMPTY]               = ctl_q.cmd_empty;
    status_view[hmp_pkg::STAT_RESET_N]                 = rst_int_n;           // R8
  end

  always_comb begin
    flags_view                                  = hmp_pkg::FLG_ONES_MASK;  // R18
    flags_view[hmp_pkg::FLG_OUT_SLOT_EMPTY]     = ~ctl_q.out_pending;      // R12
    flags_view[hmp_pkg::FLG_IN_AVAIL]           = ctl_q.in_full;           // R13
    flags_view[hmp_pkg::FLG_HOST_INT_PEND]      = ctl_q.host_int_pend;     // R14
    flags_view[hmp_pkg::FLG_STATUS_SLOT_EMPTY]  = ctl_q.status_empty;      // R15
    flags_view[hmp_pkg::FLG_CMD_AVAIL]          = ctl_q.cmd_avail;         // R19
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next control state

  always_comb begin
    ctl_d = ctl_q;

    // Software status bits; bits 7, 6 and 0 of the write are dropped
    if (loc_stat_wr) begin
      ctl_d.stat_sw = loc_wdata_i[hmp_pkg::STAT_SW_HI:hmp_pkg::STAT_SW_LO]; // R7
    end

    // Command handshake. A host write landing with a local status write
    // wins, so a fresh command is never reported as already consumed.
    if (host_cmd_wr) begin
      ctl_d.cmd_empty = 1'h0;                                   // R3
    end else if (loc_stat_wr) begin
      ctl_d.cmd_empty = loc_wdata_i[hmp_pkg::STAT_CMD_EMPTY];   // R4
    end
    if (host_cmd_wr) begin
      ctl_d.cmd_avail = 1'h1;                                   // R19
    end else if (loc_stat_wr && loc_wdata_i[hmp_pkg::STAT_CMD_EMPTY]) begin
      ctl_d.cmd_avail = 1'h0;                                   // R19
    end

    // Host-to-local slot; set wins over clear
    if (host_data_wr) begin
      ctl_d.in_full = 1'h1;                                     // R5 R13
    end else if (loc_data_rd) begin
      ctl_d.in_full = 1'h0;                                     // R5 R13
    end

    // Local-to-host slot; set wins over clear
    if (loc_data_wr) begin
      ctl_d.out_pending = 1'h1;                                 // R6 R12
    end else if (host_data_rd) begin
      ctl_d.out_pending = 1'h0;                                 // R6 R12
    end

    // Status slot; the host read is the hardware event and wins
    if (host_stat_rd) begin
      ctl_d.status_empty = 1'h1;                                // R15
    end else if (loc_stat_wr) begin
      ctl_d.status_empty = 1'h0;                                // R15
    end

    // Control register: only the two enables exist
    if (loc_ctl_wr) begin
      ctl_d.host_ie = loc_wdata_i[hmp_pkg::CTL_HOST_IE];        // R21
      ctl_d.loc_ie  = loc_wdata_i[hmp_pkg::CTL_LOC_IE];         // R20
    end

    // Local interrupt; a new host access beats an acknowledge
    if (host_access && ctl_q.loc_ie) begin
      ctl_d.loc_int_pend = 1'h1;                                // R9
    end else if (loc_ack) begin
      ctl_d.loc_int_pend = 1'h0;
    end
    if (loc_ack) begin
      ctl_d.loc_vec = hmp_pkg::LOC_INT_VECTOR;                  // R20
    end

    // Host interrupt. Clearing the enable does not drop a pending request.
    if (loc_vec_wr && ctl_q.host_ie) begin
      ctl_d.host_int_pend = 1'h1;                               // R16 R22
    end else if (host_ack) begin
      ctl_d.host_int_pend = 1'h0;                               // R21
    end
    if (host_ack) begin
      ctl_d.host_vec = dat_q.vector;                            // R21
    end

    // Read data is captured on the strobe and held until the next read
    if (host_stat_rd) begin
      ctl_d.host_rdata = status_view;
    end else if (host_data_rd) begin
      ctl_d.host_rdata = dat_q.out_data;                        // R11
    end
    if (loc_rd_any) begin
      case (loc_addr_i)
        hmp_pkg::LOC_OFS_CMD_STAT:  ctl_d.loc_rdata = dat_q.cmd;      // R1
        hmp_pkg::LOC_OFS_DATA:      ctl_d.loc_rdata = dat_q.in_data;  // R10
        hmp_pkg::LOC_OFS_FLAGS_CTL: ctl_d.loc_rdata = flags_view;     // R18
        default:                    ctl_d.loc_rdata = hmp_pkg::UNUSED_READ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next mailbox bytes

  always_comb begin
    dat_d = dat_q;
    if (host_cmd_wr) begin
      dat_d.cmd = host_wdata_i;          // R1
    end
    if (host_data_wr) begin
      dat_d.in_data = host_wdata_i;      // R10
    end
    if (loc_data_wr) begin
      dat_d.out_data = loc_wdata_i;      // R11
    end
    if (loc_vec_wr && ctl_q.host_ie) begin
      dat_d.vector = loc_wdata_i;        // R22
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers

  always_ff @(posedge sys_clk_i or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ctl_q.stat_sw       <= hmp_pkg::RST_STAT_SW;       // R7
      ctl_q.cmd_empty     <= hmp_pkg::RST_CMD_EMPTY;     // R4
      ctl_q.cmd_avail     <= hmp_pkg::RST_CLEAR;         // R19
      ctl_q.in_full       <= hmp_pkg::RST_CLEAR;         // R5 R13
      ctl_q.out_pending   <= hmp_pkg::RST_CLEAR;         // R6 R12
      ctl_q.status_empty  <= hmp_pkg::RST_STATUS_EMPTY;  // R15
      ctl_q.host_ie       <= hmp_pkg::RST_CLEAR;         // R21
      ctl_q.loc_ie        <= hmp_pkg::RST_CLEAR;         // R20
      ctl_q.host_int_pend <= hmp_pkg::RST_CLEAR;         // R21
      ctl_q.loc_int_pend  <= hmp_pkg::RST_CLEAR;
      ctl_q.host_rdata    <= hmp_pkg::RST_BYTE;
      ctl_q.loc_rdata     <= hmp_pkg::RST_BYTE;
      ctl_q.host_vec      <= hmp_pkg::RST_BYTE;
      ctl_q.loc_vec       <= hmp_pkg::RST_BYTE;
    end else if (clk_en_i) begin
      ctl_q <= ctl_d;
    end
  end

  // No reset here: the bytes must survive a board reset untouched
  always_ff @(posedge sys_clk_i) begin
    if (clk_en_i) begin
      dat_q <= dat_d;                    // R1 R10 R11 R22
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign host_rdata_o = ctl_q.host_rdata;
  assign host_int_n_o = ~ctl_q.host_int_pend;   // R14 R16
  assign host_vec_o   = ctl_q.host_vec;
  assign loc_rdata_o  = ctl_q.loc_rdata;
  assign loc_int_o    = ctl_q.loc_int_pend;
  assign loc_vec_o    = ctl_q.loc_vec;

endmodule : hmp_mailbox

/* File: verification/hmp_mailbox_asserts.sv */
/*
  Port checker for hmp_mailbox, bound to every instance of it.
  Assumes one clock and strobes that are single enabled cycles.
*/
`timescale 1ns/1ps
module hmp_mailbox_asserts (
  // Clock, reset, enable
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic       clk_en_i,
  // Host side
  input wire logic       host_addr_i,
  input wire logic       host_wr_i,
  input wire logic       host_rd_i,
  input wire logic [7:0] host_rdata_o,
  input wire logic       host_int_n_o,
  input wire logic       host_inta_i,
  // Local side
  input wire logic [1:0] loc_addr_i,
  input wire logic       loc_wr_i,
  input wire logic       loc_rd_i,
  input wire logic [7:0] loc_rdata_o,
  input wire logic       loc_int_o,
  input wire logic       loc_inta_i,
  input wire logic [7:0] loc_vec_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  wire logic hacc = clk_en_i && (host_wr_i || host_rd_i);
  wire logic hsr  = clk_en_i && host_rd_i && !host_addr_i;
  wire logic lfr  = clk_en_i && loc_rd_i && loc_addr_i == 2'h2;
  wire logic lvw  = clk_en_i && loc_wr_i && loc_addr_i == 2'h3;
  ////////////////////////////////////////////////////////////////////////////
  host_ack_a: assert property (clk_en_i && host_inta_i && !lvw |=> host_int_n_o)
    else $error("host request still low after acknowledge");
  host_cause_a: assert property ($fell(host_int_n_o) |-> $past(lvw))
    else $error("host request without vector write");
  loc_clr_a: assert property (clk_en_i && loc_inta_i && !hacc |=> !loc_int_o)
    else $error("local interrupt kept after acknowledge");
  loc_vec_a: assert property (clk_en_i && loc_inta_i |=> loc_vec_o == 8'hfc)
    else $error("wrong local vector");
  stat_live_a: assert property (hsr |=> host_rdata_o[0])
    else $error("status reset bit low outside reset");
  flag_ones_a: assert property (lfr |=> (loc_rdata_o & 8'h34) == 8'h34)
    else $error("fixed flag bits not one");
  flag_pend_a: assert property (lfr |=> loc_rdata_o[3] == !$past(host_int_n_o))
    else $error("pending flag disagrees with host request");
  // Spacing of one idle cycle matches the bench's bus tasks
  cmd_empty_a: assert property (clk_en_i && host_wr_i && !host_addr_i ##1 !loc_wr_i
    ##1 hsr && !loc_wr_i |=> !host_rdata_o[1]) else $error("command empty still set");
  cover property (lvw ##1 !host_int_n_o);
  cover property (hacc ##1 loc_int_o);
  cover property (clk_en_i && host_inta_i ##1 host_int_n_o);
endmodule : hmp_mailbox_asserts

bind hmp_mailbox hmp_mailbox_asserts u_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .host_addr_i(host_addr_i),
  .host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .host_rdata_o(host_rdata_o),
  .host_int_n_o(host_int_n_o), .host_inta_i(host_inta_i), .loc_addr_i(loc_addr_i),
  .loc_wr_i(loc_wr_i), .loc_rd_i(loc_rd_i), .loc_rdata_o(loc_rdata_o),
  .loc_int_o(loc_int_o), .loc_inta_i(loc_inta_i), .loc_vec_o(loc_vec_o));

/* File: verification/hmp_host_model.sv */
/*
  Host processor doing port I/O on the mailbox; its tasks are called by the bench.
  Assumes the bench waits out reset before the first call.
*/
`timescale 1ns/1ps
module hmp_host_model (
  // Clock and returned byte
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] rdata_i,
  // Strobes, address and write byte
  output logic            addr_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic            inta_o,
  output logic      [7:0] wdata_o
);
  initial {addr_o, wr_o, rd_o, inta_o, wdata_o} = 12'h000;
  // Callers keep clear of the reserved reset series and wait for an empty slot,
  // except where a scenario overwrites on purpose; a released bus shows the inverse
  task put(input logic a, input logic [7:0] d);
    @(posedge sys_clk_i) #1 {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
    @(posedge sys_clk_i) #1 {addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
  endtask : put
  task get(input logic a, output logic [7:0] d);
    @(posedge sys_clk_i) #1 {addr_o, rd_o} = {a, 1'b1};
    @(posedge sys_clk_i) #1 {addr_o, rd_o} = {~a, 1'b0};
    d = rdata_i;
  endtask : get
  task ack;
    @(posedge sys_clk_i) #1 inta_o = 1'b1;
    @(posedge sys_clk_i) #1 inta_o = 1'b0;
  endtask : ack
endmodule : hmp_host_model

/* File: verification/hmp_mailbox_tb_top.sv */
/*
  Self-checking bench for hmp_mailbox; host side is hmp_host_model.
  Assumes the checker is bound in by its own file.
*/
`timescale 1ns/1ps
module hmp_mailbox_tb_top;
  logic       sys_clk_i = 1'b0;
  logic       rst_n_i   = 1'b0;
  logic       l_w = 1'b0, l_r = 1'b0, l_k = 1'b0, en = 1'b1;
  logic       h_a, h_w, h_r, h_k, h_n, l_i;
  logic [1:0] l_a = 2'h0;
  logic [7:0] l_d = 8'h00, h_d, h_q, h_v, l_q, l_v, v;
  int         fails = 0, tests_run = 0, cyc = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  hmp_host_model u_host (.sys_clk_i(sys_clk_i), .rdata_i(h_q), .addr_o(h_a), .wr_o(h_w),
    .rd_o(h_r), .inta_o(h_k), .wdata_o(h_d));
  hmp_mailbox u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(en),
    .host_addr_i(h_a), .host_wr_i(h_w), .host_rd_i(h_r), .host_wdata_i(h_d),
    .host_rdata_o(h_q), .host_int_n_o(h_n), .host_inta_i(h_k), .host_vec_o(h_v),
    .loc_addr_i(l_a), .loc_wr_i(l_w), .loc_rd_i(l_r), .loc_wdata_i(l_d),
    .loc_rdata_o(l_q), .loc_int_o(l_i), .loc_inta_i(l_k), .loc_vec_o(l_v));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      fails++;
    end
  endtask : chk
  task lwr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk_i) #1 {l_a, l_d, l_w} = {a, d, 1'b1};
    @(posedge sys_clk_i) #1 {l_d, l_w} = {~d, 1'b0};
  endtask : lwr
  task lchk(input string n, input logic [1:0] a, input logic [7:0] e);
    @(posedge sys_clk_i) #1 {l_a, l_r} = {a, 1'b1};
    @(posedge sys_clk_i) #1 l_r = 1'b0;
    chk(n, e, l_q);
  endtask : lchk
  task hchk(input string n, input logic a, input logic [7:0] e);
    u_host.get(a, v);
    chk(n, e, v);
  endtask : hchk
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  task t_cmd;
    hchk("status", 1'b0, 8'h83);
    lchk("flags", 2'h2, 8'hb6);
    u_host.put(1'b0, 8'h5a);
    hchk("status", 1'b0, 8'h81);
    lchk("command", 2'h0, 8'h5a);
    lchk("flags", 2'h2, 8'hb7);
    lwr(2'h0, 8'h3c);
    lchk("flags", 2'h2, 8'hb5);
    hchk("status", 1'b0, 8'hbd);
    lwr(2'h0, 8'hc3);
    hchk("status", 1'b0, 8'h83);
    lchk("flags", 2'h2, 8'hb6);
    $display("test command done");
  endtask : t_cmd
  task t_data;
    u_host.put(1'b1, 8'ha5);
    u_host.put(1'b1, 8'h96);
    hchk("status", 1'b0, 8'h03);
    lchk("flags", 2'h2, 8'hf6);
    lchk("in data", 2'h1, 8'h96);
    lchk("in data", 2'h1, 8'h96);
    lwr(2'h1, 8'h11);
    lwr(2'h1, 8'h22);
    hchk("status", 1'b0, 8'hc3);
    lchk("flags", 2'h2, 8'h36);
    hchk("out data", 1'b1, 8'h22);
    hchk("out data", 1'b1, 8'h22);
    hchk("status", 1'b0, 8'h83);
    lchk("flags", 2'h2, 8'hb6);
    $display("test data done");
  endtask : t_data
  task t_hint;
    lwr(2'h0, 8'h02);
    lwr(2'h2, 8'h00);
    lwr(2'h3, 8'h3c);
    chk("host irq", 8'h01, {7'h00, h_n});
    lwr(2'h2, 8'h01);
    lwr(2'h3, 8'h5e);
    chk("host irq", 8'h00, {7'h00, h_n});
    lchk("flags", 2'h2, 8'hbc);
    lwr(2'h2, 8'h00);
    chk("host irq", 8'h00, {7'h00, h_n});
    u_host.ack();
    chk("host irq", 8'h01, {7'h00, h_n});
    chk("host vector", 8'h5e, h_v);
    lchk("flags", 2'h2, 8'hb4);
    $display("test host interrupt done");
  endtask : t_hint
  task t_lint;
    lwr(2'h2, 8'h04);
    // Status read, data read, command write, data write
    for (int k = 0; k < 4; k++) begin
      if (k < 2) hchk("host read", k[0], k[0] ? 8'h22 : 8'h83);
      else u_host.put(k[0], 8'h01);
      chk("local irq", 8'h01, {7'h00, l_i});
      @(posedge sys_clk_i) #1 l_k = 1'b1;
      @(posedge sys_clk_i) #1 l_k = 1'b0;
      chk("local irq", 8'h00, {7'h00, l_i});
      chk("local vector", 8'hfc, l_v);
    end
    lwr(2'h2, 8'h00);
    hchk("status", 1'b0, 8'h01);
    chk("local irq", 8'h00, {7'h00, l_i});
    $display("test local interrupt done");
  endtask : t_lint
  task t_rst2;
    lwr(2'h2, 8'h01);
    lwr(2'h3, 8'h77);
    @(posedge sys_clk_i) #1 rst_n_i = 1'b0;
    @(posedge sys_clk_i) #1 chk("host irq", 8'h01, {7'h00, h_n});
    rst_n_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    lchk("flags", 2'h2, 8'hb6);
    lchk("in data", 2'h1, 8'h01);
    lchk("command", 2'h0, 8'h01);
    hchk("out data", 1'b1, 8'h22);
    u_host.ack();
    chk("host vector", 8'h77, h_v);
    $display("test second reset done");
  endtask : t_rst2
  task t_freeze;
    @(posedge sys_clk_i) #1 en = 1'b0;
    u_host.put(1'b1, 8'h3e);
    en = 1'b1;
    hchk("status", 1'b0, 8'h83);
    lchk("in data", 2'h1, 8'h01);
    $display("test clock enable done");
  endtask : t_freeze
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk_i);
    #1 rst_n_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    t_cmd();
    t_data();
    t_hint();
    t_lint();
    t_rst2();
    t_freeze();
    close_out();
  end
endmodule : hmp_mailbox_tb_top
